// ===== shared/dbc_pkg.sv
// dbc_pkg: register map, field layout, reset values, timing counts and
// carriers of the DMA bus configuration block.
// assumes a 32-bit Avalon-MM slave decoded on byte addresses.
package dbc_pkg;
   localparam logic [7:0] DBC_OFS_COUNT = 8'h34;
   localparam logic [7:0] DBC_OFS_CONFIG = 8'h38;
   localparam logic [7:0] DBC_OFS_HWMODE = 8'h3C;
   localparam logic [7:0] DBC_OFS_STATUS = 8'h40;

   localparam int DBC_CFG_ATA_BIT = 13;
   localparam int DBC_CFG_MTIM_LSB = 11;
   localparam int DBC_CFG_PIO_LSB = 8;
   localparam int DBC_CFG_CNTOFF_BIT = 7;
   localparam int DBC_CFG_STRB_LSB = 2;
   localparam int DBC_CFG_WIDTH_BIT = 0;
   localparam int DBC_HW_MASTER_BIT = 4;
   localparam int DBC_HW_SWAP_LSB = 6;
   localparam int DBC_ST_EMPTY_BIT = 0;
   localparam int DBC_ST_FULL_BIT = 1;
   localparam int DBC_ST_ZERO_BIT = 2;
   localparam int DBC_ST_ARMED_BIT = 3;
   localparam int DBC_ST_SINK_BIT = 4;
   localparam int DBC_ST_BUSY_BIT = 5;

   localparam int DBC_DATA_W = 16;
   localparam int DBC_FIFO_DEPTH = 16;

   localparam logic [1:0] DBC_MAP_RA = 2'h1;
   localparam logic [1:0] DBC_MAP_ACK = 2'h2;
   localparam logic [1:0] DBC_MTIM_CUSTOM = 2'h3;
   localparam logic [1:0] DBC_SWAP_ON = 2'h1;

   localparam logic [3:0] DBC_ACT_MODE0 = 4'h8;
   localparam logic [3:0] DBC_ACT_MODE1 = 4'h4;
   localparam logic [3:0] DBC_ACT_MODE2 = 4'h3;
   localparam logic [3:0] DBC_RECOVER = 4'h2;

   // bit 0 read strobe, bit 1 write strobe, bit 2 acknowledge
   typedef struct packed {
      logic ack;
      logic write;
      logic read;
   } dbc_strobe_s;

   typedef struct packed {
      logic ataPath;
      logic [1:0] masterTiming;
      logic [2:0] pioTiming;
      logic byteCounterOff;
      logic [1:0] strobeMap;
      logic width16;
   } dbc_cfg_s;

   typedef struct packed {
      logic [1:0] laneSwap;
      logic master;
   } dbc_hw_s;

   localparam logic [31:0] DBC_COUNT_RESET = 32'h0000_0000;
   localparam dbc_cfg_s DBC_CFG_RESET =
      '{ataPath: 1'b0, masterTiming: 2'h0, pioTiming: 3'h0,
        byteCounterOff: 1'b0, strobeMap: 2'h0, width16: 1'b1};
   localparam dbc_hw_s DBC_HW_RESET = '{laneSwap: 2'h0, master: 1'b0};
endpackage

// ===== rtl/dbc_fifo.sv
// dbc_fifo: flip-flop FIFO with valid/ready on both sides.
// assumes DEPTH is a power of two; one clock, clock enable freezes it.
`timescale 1ns/1ps
`default_nettype none
module dbc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic flush,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrIdx;
   logic [AW-1:0] rdIdx;
   logic [AW:0] count;
   logic [AW:0] next_count;

   wire push = inValid & inReady;
   wire pop = outValid & outReady;

   assign inReady = (count != FULL_COUNT);
   assign outValid = (count != '0);
   assign outData = mem[rdIdx];
   assign level = count;

   always_comb begin
      unique case ({push, pop})
         2'b10: next_count = count + (AW+1)'(1);
         2'b01: next_count = count - (AW+1)'(1);
         default: next_count = count;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wrIdx <= '0;
         rdIdx <= '0;
         count <= '0;
      end else if (ce) begin
         if (flush) begin
            wrIdx <= '0;
            rdIdx <= '0;
            count <= '0;
         end else begin
            if (push) wrIdx <= wrIdx + AW'(1);
            if (pop) rdIdx <= rdIdx + AW'(1);
            count <= next_count;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (ce && push && !flush) mem[wrIdx] <= inData;
   end
endmodule
`default_nettype wire

// ===== rtl/dbc_dma_bus_config.sv
// dbc_dma_bus_config: DMA bus configuration, strobe routing, byte counter
// and outbound buffering of a USB peripheral controller's DMA port.
// assumes pins are synchronous to clk; internal signal levels are
// active high (pin polarity is handled outside this block).
`timescale 1ns/1ps
`default_nettype none
module dbc_dma_bus_config #(
   parameter int FIFO_DEPTH = dbc_pkg::DBC_FIFO_DEPTH,
   parameter logic [3:0] ACT_MODE0 = dbc_pkg::DBC_ACT_MODE0,
   parameter logic [3:0] ACT_MODE1 = dbc_pkg::DBC_ACT_MODE1,
   parameter logic [3:0] ACT_MODE2 = dbc_pkg::DBC_ACT_MODE2,
   parameter logic [3:0] RECOVER = dbc_pkg::DBC_RECOVER
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic busReset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire dbc_pkg::dbc_strobe_s strobeIn,
   output dbc_pkg::dbc_strobe_s strobeOut,
   output dbc_pkg::dbc_strobe_s strobeOe,
   input wire logic dmaRequestIn,
   output logic dmaRequestOut,
   output logic dmaRequestOe,
   input wire logic [15:0] busDataIn,
   output logic [15:0] busDataOut,
   output logic busDataOe,
   input wire logic dirOut,
   input wire logic [3:0] customActiveCycles,
   input wire logic srcValid,
   output logic srcReady,
   input wire logic [15:0] srcData,
   output logic sinkValid,
   input wire logic sinkReady,
   output logic [15:0] sinkData,
   output dbc_pkg::dbc_cfg_s cfg
);
   import dbc_pkg::*;

   typedef enum logic [1:0] {GEN_IDLE, GEN_ACTIVE, GEN_RECOVER} dbc_gen_e;

   // one-hot strobe that captures (capture=1) or drives data for a role
   function automatic logic [2:0] strobeSel(input logic [1:0] map,
                                           input logic master,
                                           input logic capture);
      logic [2:0] rd;
      logic [2:0] wr;
      logic [2:0] ack;
      rd = 3'h1;
      wr = 3'h2;
      ack = 3'h4;
      case (map)
         DBC_MAP_RA:
            strobeSel = (capture == master) ? rd : ack;
         DBC_MAP_ACK:
            strobeSel = ack;
         default:
            strobeSel = (capture == master) ? rd : wr;
      endcase
   endfunction

   // bus lanes to internal word, both directions alike
   function automatic logic [15:0] laneFormat(input logic [15:0] w,
                                             input logic width16,
                                             input logic [1:0] swap);
      if (!width16)
         laneFormat = {8'h00, w[7:0]};
      else if (swap == DBC_SWAP_ON)
         laneFormat = {w[7:0], w[15:8]};
      else
         laneFormat = w;
   endfunction

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
      mergeBytes = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) mergeBytes[8*i +: 8] = wd[8*i +: 8];
      end
   endfunction

   function automatic logic [15:0] cfgPack(input dbc_cfg_s c);
      cfgPack = 16'h0000;
      cfgPack[DBC_CFG_ATA_BIT] = c.ataPath;
      cfgPack[DBC_CFG_MTIM_LSB +: 2] = c.masterTiming;
      cfgPack[DBC_CFG_PIO_LSB +: 3] = c.pioTiming;
      cfgPack[DBC_CFG_CNTOFF_BIT] = c.byteCounterOff;
      cfgPack[DBC_CFG_STRB_LSB +: 2] = c.strobeMap;
      cfgPack[DBC_CFG_WIDTH_BIT] = c.width16;
   endfunction

   function automatic logic [7:0] hwPack(input dbc_hw_s h);
      hwPack = 8'h00;
      hwPack[DBC_HW_MASTER_BIT] = h.master;
      hwPack[DBC_HW_SWAP_LSB +: 2] = h.laneSwap;
   endfunction

   // register bus slave: one wait cycle, then the answer
   logic rsp;
   logic [31:0] count;
   dbc_hw_s hw;
   logic armed;
   wire avReq = avs_read | avs_write;
   wire avFirst = avReq & ~rsp & ce;
   wire wrTake = avs_write & rsp & ce;
   wire hitCount = (avs_address == DBC_OFS_COUNT);
   wire hitConfig = (avs_address == DBC_OFS_CONFIG);
   wire hitHw = (avs_address == DBC_OFS_HWMODE);
   wire hitStatus = (avs_address == DBC_OFS_STATUS);
   wire wrCount = wrTake & hitCount;
   wire wrConfig = wrTake & hitConfig;
   wire wrHw = wrTake & hitHw;
   assign avs_waitrequest = avReq & ~(rsp & ce);

   wire [31:0] cntMerged = mergeBytes(count, avs_writedata,
                                      avs_byteenable);
   wire [31:0] cfgMerged = mergeBytes({16'h0000, cfgPack(cfg)},
                                      avs_writedata, avs_byteenable);
   wire [31:0] hwMerged = mergeBytes({24'h000000, hwPack(hw)},
                                     avs_writedata, avs_byteenable);

   // role and counter qualification
   wire roleMaster = hw.master;
   wire masterDrive = roleMaster & cfg.ataPath;
   wire cntEnabled = ~(cfg.byteCounterOff & ~roleMaster);
   wire countZero = (count == 32'h0000_0000);
   wire countBlock = cntEnabled & countZero;

   // outbound buffer
   logic fifoValid;
   logic fifoFull;
   logic [15:0] fifoData;
   logic [$clog2(FIFO_DEPTH):0] fifoLevel;
   logic drvFall;
   wire fifoPop = drvFall & fifoValid & ~countBlock;

   dbc_fifo #(.WIDTH(DBC_DATA_W), .DEPTH(FIFO_DEPTH)) outFifo (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .flush(busReset),
      .inValid(srcValid),
      .inReady(srcReady),
      .inData(srcData),
      .outValid(fifoValid),
      .outReady(fifoPop),
      .outData(fifoData),
      .level(fifoLevel)
   );
   assign fifoFull = (fifoLevel == ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH));

   // strobe routing
   dbc_gen_e genState;
   logic [3:0] genCnt;
   logic [2:0] strbPrev;
   wire [2:0] capSel = strobeSel(cfg.strobeMap, roleMaster, 1'b1);
   wire [2:0] drvSel = strobeSel(cfg.strobeMap, roleMaster, 1'b0);
   wire [2:0] genOnehot = (genState == GEN_ACTIVE) ?
                          (dirOut ? drvSel : capSel) : 3'h0;
   wire [2:0] strbNow = masterDrive ? genOnehot : strobeIn;
   wire capLevel = |(strbNow & capSel);
   wire drvLevel = |(strbNow & drvSel);
   wire capFall = |(strbPrev & capSel) & ~capLevel & ~dirOut;
   assign drvFall = |(strbPrev & drvSel) & ~drvLevel & dirOut;

   wire sinkFree = ~sinkValid | sinkReady;
   wire capTake = capFall & sinkFree & ~countBlock;
   wire xferDone = capTake | fifoPop;
   wire workAvail = dirOut ? fifoValid : sinkFree;
   wire okToMove = workAvail & ~countBlock;
   wire [31:0] step = cfg.width16 ? 32'h0000_0002 : 32'h0000_0001;

   assign strobeOut = dbc_strobe_s'(genOnehot);
   assign strobeOe = dbc_strobe_s'({3{masterDrive}});
   assign busDataOe = drvLevel & dirOut & fifoValid;
   assign dmaRequestOut = okToMove;
   assign dmaRequestOe = armed & ~masterDrive;

   // master strobe length per timing mode
   logic [3:0] activeLen;
   always_comb begin
      unique case (cfg.masterTiming)
         2'h0: activeLen = ACT_MODE0;
         2'h1: activeLen = ACT_MODE1;
         2'h2: activeLen = ACT_MODE2;
         DBC_MTIM_CUSTOM:
            activeLen = (customActiveCycles == 4'h0) ? 4'h1 :
                        customActiveCycles;
      endcase
   end

   // next-state of the configuration registers
   dbc_cfg_s next_cfg;
   dbc_hw_s next_hw;
   logic [31:0] next_count;
   logic next_armed;
   always_comb begin
      next_cfg = cfg;
      next_hw = hw;
      next_armed = armed;
      if (busReset) begin
         next_cfg = DBC_CFG_RESET;
         next_hw = DBC_HW_RESET;
         next_armed = 1'b0;
      end else begin
         if (wrConfig) begin
            next_cfg.ataPath = cfgMerged[DBC_CFG_ATA_BIT];
            next_cfg.masterTiming = cfgMerged[DBC_CFG_MTIM_LSB +: 2];
            next_cfg.pioTiming = cfgMerged[DBC_CFG_PIO_LSB +: 3];
            next_cfg.byteCounterOff = cfgMerged[DBC_CFG_CNTOFF_BIT];
            next_cfg.strobeMap = cfgMerged[DBC_CFG_STRB_LSB +: 2];
            next_cfg.width16 = cfgMerged[DBC_CFG_WIDTH_BIT];
            next_armed = 1'b1;
         end
         if (wrHw) begin
            next_hw.master = hwMerged[DBC_HW_MASTER_BIT];
            next_hw.laneSwap = hwMerged[DBC_HW_SWAP_LSB +: 2];
         end
      end
   end

   always_comb begin
      next_count = count;
      if (busReset)
         next_count = DBC_COUNT_RESET;
      else if (wrCount)
         next_count = cntMerged;
      else if (xferDone)
         next_count = count - step;
   end

   wire [5:0] statusBits = {genState != GEN_IDLE, sinkValid, armed,
                            countZero, fifoFull, ~fifoValid};
   wire [31:0] rdMux =
      hitCount ? count :
      hitConfig ? {16'h0000, cfgPack(cfg)} :
      hitHw ? {24'h000000, hwPack(hw)} :
      hitStatus ? {26'h0, statusBits} : 32'h0000_0000;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsp <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else if (ce) begin
         rsp <= avReq & ~rsp;
         if (avFirst) avs_readdata <= rdMux;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg <= DBC_CFG_RESET;
         hw <= DBC_HW_RESET;
         count <= DBC_COUNT_RESET;
         armed <= 1'b0;
      end else if (ce) begin
         cfg <= next_cfg;
         hw <= next_hw;
         count <= next_count;
         armed <= next_armed;
      end
   end

   // master strobe generator, only in ATA/master operation
   dbc_gen_e next_genState;
   logic [3:0] next_genCnt;
   always_comb begin
      next_genState = genState;
      next_genCnt = genCnt;
      if (busReset || !masterDrive) begin
         next_genState = GEN_IDLE;
         next_genCnt = 4'h0;
      end else begin
         unique case (genState)
            GEN_IDLE:
               if (dmaRequestIn && okToMove) begin
                  next_genState = GEN_ACTIVE;
                  next_genCnt = activeLen - 4'h1;
               end
            GEN_ACTIVE:
               if (genCnt == 4'h0) begin
                  next_genState = GEN_RECOVER;
                  next_genCnt = (RECOVER == 4'h0) ? 4'h0 :
                                RECOVER - 4'h1;
               end else begin
                  next_genCnt = genCnt - 4'h1;
               end
            GEN_RECOVER:
               if (genCnt == 4'h0)
                  next_genState = GEN_IDLE;
               else
                  next_genCnt = genCnt - 4'h1;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         genState <= GEN_IDLE;
         genCnt <= 4'h0;
         strbPrev <= 3'h0;
      end else if (ce) begin
         genState <= next_genState;
         genCnt <= next_genCnt;
         strbPrev <= strbNow;
      end
   end

   // data path registers; lane swap assumed 00 on the narrow bus
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         busDataOut <= 16'h0000;
         sinkValid <= 1'b0;
         sinkData <= 16'h0000;
      end else if (ce) begin
         busDataOut <= laneFormat(fifoData, cfg.width16,
                                  hw.laneSwap);
         if (busReset)
            sinkValid <= 1'b0;
         else if (capTake)
            sinkValid <= 1'b1;
         else if (sinkReady)
            sinkValid <= 1'b0;
         if (capTake)
            sinkData <= laneFormat(busDataIn, cfg.width16, hw.laneSwap);
      end
   end
endmodule
`default_nettype wire

// ===== testbench/dbc_dma_bus_config_sva.sv
// dbc_dma_bus_config_sva: port-level checks of the DMA bus configuration
// block; bound to the top module, sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dbc_dma_bus_config_sva
   import dbc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic busReset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire dbc_pkg::dbc_strobe_s strobeOe,
   input wire logic dmaRequestOe,
   input wire logic sinkValid,
   input wire logic [15:0] sinkData,
   input wire dbc_pkg::dbc_cfg_s cfg
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   logic cfgWrite;
   logic wrote;
   assign cfgWrite = avs_write && !avs_waitrequest && ce &&
                     avs_address == DBC_OFS_CONFIG;
   // remembers a completed write to the config register since any reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wrote <= 1'b0;
      end else if (ce && busReset) begin
         wrote <= 1'b0;
      end else if (cfgWrite) begin
         wrote <= 1'b1;
      end
   end
   a_req_held_off: assert property (!wrote |-> !dmaRequestOe)
      else $error("request pin driven before config write");
   a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
      && ce |=> !avs_waitrequest)
      else $error("register access took more than one wait state");
   a_cfg_update: assert property (cfgWrite && !busReset &&
      avs_byteenable == 4'hF |=> cfg == {$past(avs_writedata[13:7]),
      $past(avs_writedata[3:2]), $past(avs_writedata[0])})
      else $error("config fields differ from written value");
   a_cfg_hold: assert property (!cfgWrite && !busReset |=> $stable(cfg))
      else $error("config changed without a write");
   a_reset_value: assert property ($rose(resetn) |-> cfg == DBC_CFG_RESET)
      else $error("config reset value wrong");
   a_busrst_default: assert property (busReset && ce |=>
      cfg == DBC_CFG_RESET && !dmaRequestOe)
      else $error("bus reset did not restore defaults");
   a_rsvd_read_zero: assert property (avs_read && !avs_waitrequest && ce &&
      avs_address == DBC_OFS_CONFIG |-> (avs_readdata & 32'hFFFF_C072) == 0)
      else $error("reserved config bits read nonzero");
   a_role_exclusive: assert property (dmaRequestOe |-> strobeOe == 3'h0)
      else $error("request pin and strobes driven together");
   a_non_ata_quiet: assert property (!cfg.ataPath |-> strobeOe == 3'h0)
      else $error("strobes driven outside ata path");
   a_narrow_upper: assert property (sinkValid && !cfg.width16 |->
      sinkData[15:8] == 8'h00)
      else $error("eight-bit capture has upper byte set");
   c_cfg_write: cover property (cfgWrite);
   c_narrow_word: cover property (sinkValid && !cfg.width16);
   c_master_drive: cover property (strobeOe == 3'h7);
endmodule
`default_nettype wire

// ===== testbench/dbc_dma_peer.sv
// dbc_dma_peer: external DMA controller facing the block in slave role;
// pulses the capture or drive strobe that the strobe map names.
// assumes pulse() is called right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module dbc_dma_peer
   import dbc_pkg::*;
(
   input wire logic clk,
   output var dbc_pkg::dbc_strobe_s strobeIn,
   output logic [15:0] busDataIn
);
   function automatic dbc_strobe_s pick(input logic [1:0] m,
                                        input logic drv);
      pick = '0;
      if (m == 2'h2) begin
         pick.ack = 1'b1;
      end else if (m == 2'h1) begin
         pick.ack = !drv;
         pick.read = drv;
      end else begin
         pick.write = !drv;
         pick.read = drv;
      end
   endfunction
   // map 11 is never used; a released bus shows the inverse word
   task automatic pulse(input logic [1:0] m, input logic drv,
                        input logic [15:0] d, input int hold);
      busDataIn <= d;
      strobeIn <= pick(m, drv);
      repeat (hold) @(posedge clk);
      strobeIn <= '0;
      @(posedge clk);
      busDataIn <= ~d;
      @(posedge clk);
   endtask
   initial begin
      strobeIn = '0;
      busDataIn = 16'hFFFF;
   end
endmodule
`default_nettype wire

// ===== testbench/tb_dbc_dma_bus_config.sv
// tb_dbc_dma_bus_config: self-checking bench of the DMA bus configuration
// block; register tasks on the bus, slave strobe traffic via the peer.
// assumes a 20 MHz clock and the checker bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module tb_dbc_dma_bus_config;
   import dbc_pkg::*;
   logic clk, resetn, busReset, avsRead, avsWrite, avsWait, dirOut;
   logic srcValid, srcReady, sinkValid, sinkReady, dmaRequestOe;
   logic dmaReqIn, dmaReqOut;
   logic [7:0] avsAddress;
   logic [31:0] avsWritedata, avsReaddata, seed, cnt, q, v;
   logic [15:0] srcData, sinkData, busDataOut, busDataIn;
   dbc_strobe_s strobeIn, strobeOe, strobeOut;
   dbc_cfg_s cfg;
   logic [15:0] pushed[$];
   int badCount, testsRun, cycles, n, m, w;

   dbc_dma_bus_config dbc_dma_bus_config_inst (.clk(clk), .resetn(resetn),
      .ce(1'b1), .busReset(busReset), .avs_address(avsAddress),
      .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
      .avs_byteenable(4'hF), .avs_readdata(avsReaddata),
      .avs_waitrequest(avsWait), .strobeIn(strobeIn),
      .strobeOut(strobeOut),
      .strobeOe(strobeOe), .dmaRequestIn(dmaReqIn),
      .dmaRequestOut(dmaReqOut),
      .dmaRequestOe(dmaRequestOe), .busDataIn(busDataIn),
      .busDataOut(busDataOut), .busDataOe(), .dirOut(dirOut),
      .customActiveCycles(4'h4), .srcValid(srcValid), .srcReady(srcReady),
      .srcData(srcData), .sinkValid(sinkValid), .sinkReady(sinkReady),
      .sinkData(sinkData), .cfg(cfg));
   dbc_dma_peer dbc_dma_peer_inst (.clk(clk), .strobeIn(strobeIn),
      .busDataIn(busDataIn));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         badCount++;
         endSim();
      end
   end
   function automatic logic [31:0] nextRand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         badCount++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      avsAddress <= a;
      avsWritedata <= d;
      avsWrite <= wr;
      avsRead <= !wr;
      @(posedge clk);
      while (avsWait !== 1'b0) @(posedge clk);
      q = avsReaddata;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(q, exp);
   endtask
   task automatic pop();
      sinkReady <= 1'b1;
      @(posedge clk);
      sinkReady <= 1'b0;
   endtask
   // one generated master strobe; counts the cycles it stands high
   task automatic master_dma(input logic [31:0] c, input int len);
      bus(1'b1, DBC_OFS_CONFIG, c);
      w = 0;
      dmaReqIn <= 1'b1;
      @(posedge clk);
      dmaReqIn <= 1'b0;
      repeat (20) begin
         @(negedge clk);
         if (strobeOut.read === 1'b1) w++;
      end
      check(w, len);
      check(sinkValid, 1'b1);
      check(sinkData, busDataIn);
      @(posedge clk);
      pop();
   endtask
   task automatic endSim();
      $display("comparisons %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      seed = 32'hEDEF;
      {resetn, busReset, avsRead, avsWrite, dirOut, dmaReqIn} = 6'h0;
      {srcValid, sinkReady, avsAddress, avsWritedata, srcData} = '0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rdChk(DBC_OFS_CONFIG, 32'h1);
      bus(1'b1, DBC_OFS_HWMODE, 32'h0);
      check(dmaRequestOe, 1'b0);
      // every timing code and PIO 0..4 first, then random settings
      for (n = 0; n < 17; n++) begin
         v = (n < 5) ? ((n << 8) | ((n & 3) << 11) | 1) : nextRand();
         if (v[10]) v[9:8] = 2'h0;
         if (v[3:2] == 2'h3) v[3] = 1'b0;
         bus(1'b1, DBC_OFS_CONFIG, v);
         check(dmaRequestOe, 1'b1);
         check(cfg, {v[13:7], v[3:2], v[0]});
         rdChk(DBC_OFS_CONFIG, v & 32'h3F8D);
      end
      bus(1'b1, DBC_OFS_HWMODE, 32'h10);
      bus(1'b1, DBC_OFS_CONFIG, 32'h2001);
      check(strobeOe, 32'h7);
      check(dmaRequestOe, 1'b0);
      bus(1'b1, DBC_OFS_COUNT, 32'h100);
      master_dma(32'h2001, DBC_ACT_MODE0);
      master_dma(32'h3801, 4);
      rdChk(DBC_OFS_COUNT, 32'hFC);
      bus(1'b1, DBC_OFS_HWMODE, 32'h0);
      check(strobeOe, 32'h0);
      cnt = 32'h100;
      bus(1'b1, DBC_OFS_COUNT, cnt);
      for (m = 0; m < 3; m++) begin
         for (w = 0; w < 2; w++) begin
            bus(1'b1, DBC_OFS_CONFIG, (m << 2) | w);
            v = nextRand();
            dbc_dma_peer_inst.pulse(m[1:0], 1'b0, v[15:0], m + 1);
            check(sinkValid, 1'b1);
            check(sinkData, w ? v[15:0] : {8'h00, v[7:0]});
            pop();
            cnt = cnt - (w ? 2 : 1);
            rdChk(DBC_OFS_COUNT, cnt);
         end
      end
      // swapped lanes on the wide bus, acknowledge map still set
      bus(1'b1, DBC_OFS_HWMODE, 32'h40);
      dbc_dma_peer_inst.pulse(2'h2, 1'b0, 16'h1234, 1);
      check(sinkData, 16'h3412);
      pop();
      bus(1'b1, DBC_OFS_HWMODE, 32'h0);
      bus(1'b1, DBC_OFS_COUNT, 32'h0);
      bus(1'b1, DBC_OFS_CONFIG, 32'h1);
      dbc_dma_peer_inst.pulse(2'h0, 1'b0, 16'h1234, 1);
      check(sinkValid, 1'b0);
      check(dmaReqOut, 1'b0);
      bus(1'b1, DBC_OFS_CONFIG, 32'h81);
      dbc_dma_peer_inst.pulse(2'h0, 1'b0, 16'hA5C3, 2);
      check(sinkValid, 1'b1);
      check(sinkData, 16'hA5C3);
      pop();
      rdChk(DBC_OFS_COUNT, 32'hFFFF_FFFE);
      // fill the buffer until it refuses, then drain it with slow strobes
      bus(1'b1, DBC_OFS_CONFIG, 32'h1);
      bus(1'b1, DBC_OFS_COUNT, 32'h100);
      for (n = 0; n < 20; n++) begin
         v = nextRand();
         srcValid <= 1'b1;
         srcData <= v[15:0];
         @(negedge clk);
         if (srcReady !== 1'b1) break;
         pushed.push_back(v[15:0]);
         @(posedge clk);
      end
      @(posedge clk);
      srcValid <= 1'b0;
      dirOut <= 1'b1;
      check(pushed.size(), DBC_FIFO_DEPTH);
      bus(1'b0, DBC_OFS_STATUS, 32'h0);
      check(q[DBC_ST_FULL_BIT], 1'b1);
      check(dmaReqOut, 1'b1);
      for (n = 0; n < DBC_FIFO_DEPTH; n++) begin
         @(negedge clk);
         check(busDataOut, pushed.pop_front());
         @(posedge clk);
         dbc_dma_peer_inst.pulse(2'h0, 1'b1, 16'h0, 1 + n % 3);
      end
      check(dmaReqOut, 1'b0);
      dirOut <= 1'b0;
      bus(1'b0, DBC_OFS_STATUS, 32'h0);
      check(q[DBC_ST_EMPTY_BIT], 1'b1);
      rdChk(DBC_OFS_COUNT, 32'h100 - 2 * DBC_FIFO_DEPTH);
      busReset <= 1'b1;
      @(posedge clk);
      busReset <= 1'b0;
      @(posedge clk);
      check(dmaRequestOe, 1'b0);
      rdChk(DBC_OFS_CONFIG, 32'h1);
      endSim();
   end
endmodule

bind dbc_dma_bus_config dbc_dma_bus_config_sva dbc_dma_bus_config_sva_inst (
   .clk, .resetn, .ce, .busReset, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
   .strobeOe, .dmaRequestOe, .sinkValid, .sinkData, .cfg);
`default_nettype wire
